// ==== rtl/ocp_biu_pkg.sv ====
// constants and carrier types for the bus interface unit with its merging write buffer
package ocp_biu_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int BE_W = 8;
  localparam int WB_ENTRIES = 4;
  localparam int BURST_BEATS = 4;
  localparam int MAX_READS = 10;
  localparam int LINE_LSB = 5;
  localparam int DW_LSB = 3;
  localparam logic [2:0] CMD_IDLE = 3'h0;
  localparam logic [2:0] CMD_WR = 3'h1;
  localparam logic [2:0] CMD_RD = 3'h2;
  localparam logic [2:0] SEQ_WRAP = 3'h2;
  localparam logic [2:0] SEQ_XOR = 3'h4;
  localparam logic [2:0] LEN_SINGLE = 3'h1;
  localparam logic [2:0] LEN_BURST = 3'h4;
  localparam logic [1:0] RESP_DVA = 2'h1;
  localparam logic [3:0] GATHER_WORDS = 4'h8;
  localparam logic [7:0] BE_FULL = 8'hff;
  localparam logic [7:0] BE_LO_WORD = 8'h0f;
  localparam logic [7:0] BE_HI_WORD = 8'hf0;

  typedef enum logic [1:0] {POL_UNCACHED, POL_WT, POL_WB, POL_UCA} policy_t;
  typedef enum logic [2:0] {OP_LOAD, OP_FETCH, OP_STORE, OP_EVICT, OP_BARRIER} op_t;
  typedef enum logic [1:0] {DR_IDLE, DR_CMD, DR_DATA} drain_t;

  typedef struct packed {
    logic valid;
    op_t op;
    policy_t policy;
    logic hit;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0] be;
    logic [DATA_W-1:0] wdata;
    logic [1:0] space;
  } core_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic first;
    logic last;
    logic fill;
  } core_rsp_t;

  typedef struct packed {
    logic [2:0] mcmd;
    logic [ADDR_W-1:0] maddr;
    logic [1:0] maddrspace;
    logic [2:0] mburstlength;
    logic [2:0] mburstseq;
    logic [BE_W-1:0] mbyteen;
    logic mreqinfo;
  } ocp_req_t;

  typedef struct packed {
    logic mdatavalid;
    logic [DATA_W-1:0] mdata;
    logic [BE_W-1:0] mdatabyteen;
    logic mdatalast;
  } ocp_wdata_t;

  typedef struct packed {
    logic scmdaccept;
    logic sdataaccept;
    logic [1:0] sresp;
    logic [DATA_W-1:0] sdata;
    logic sresplast;
  } ocp_in_t;

  typedef struct packed {
    logic valid;
    logic mergeable;
    logic gather;
    logic sealed;
    logic [ADDR_W-LINE_LSB-1:0] tag;
    logic [1:0] space;
    logic [3:0] gcount;
    logic [BURST_BEATS-1:0][DATA_W-1:0] data;
    logic [BURST_BEATS-1:0][BE_W-1:0] mask;
  } wb_entry_t;
endpackage

// ==== rtl/ocp_bus_interface_write_buffer.sv ====
// bus interface unit: cache-policy routing, merging write buffer and bus master port
`timescale 1ns/1ps
`default_nettype none
module ocp_bus_interface_write_buffer #(
  parameter int MAX_READS = ocp_biu_pkg::MAX_READS
)(
  input wire logic core_clk, // 40 MHz core clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic bus_in_strobe, // enables sampling of bus inputs
  input wire logic bus_out_strobe, // enables update of bus outputs
  input wire logic aligned_byte_enable_mode, // only naturally aligned enables
  input wire logic burst_xor_order, // read bursts use XOR instead of wrap
  input wire ocp_biu_pkg::core_req_t core_req, // request from load/store and fetch
  output logic core_req_ready, // request taken this cycle
  output ocp_biu_pkg::core_rsp_t core_rsp, // read data to the core
  output logic core_rsp_valid, // core_rsp holds a beat
  input wire logic core_rsp_ready, // core takes the beat
  output ocp_biu_pkg::ocp_req_t ocp_req, // bus request phase
  output ocp_biu_pkg::ocp_wdata_t ocp_wdata, // bus write data phase
  output logic ocp_resp_accept, // bus response accept
  input wire ocp_biu_pkg::ocp_in_t ocp_in, // slave answers
  output logic wbuf_empty, // write buffer holds nothing
  output logic [3:0] reads_outstanding // reads issued and not completed
);
  typedef struct packed {
    ocp_biu_pkg::wb_entry_t [ocp_biu_pkg::WB_ENTRIES-1:0] ent;
    logic [1:0] head;
    logic [2:0] count;
    logic rd_valid;
    logic rd_burst;
    logic rd_barrier;
    logic [ocp_biu_pkg::ADDR_W-1:0] rd_addr;
    logic [ocp_biu_pkg::BE_W-1:0] rd_be;
    logic [1:0] rd_space;
    ocp_biu_pkg::drain_t dr;
    logic wburst;
    logic [1:0] beat;
    logic [1:0] dsel;
    ocp_biu_pkg::ocp_req_t req;
    ocp_biu_pkg::ocp_wdata_t wdat;
    logic cmd_acc;
    logic dat_acc;
    logic resp_acc;
    logic [3:0] outstanding;
    logic barrier_wait;
    logic rfirst;
    logic rburst;
    ocp_biu_pkg::core_rsp_t [1:0] q;
    logic qrd;
    logic [1:0] qcnt;
  } st_t;

  st_t s;
  st_t next_s;
  logic [ocp_biu_pkg::WB_ENTRIES-1:0] merge_hit;
  logic is_word;
  logic is_dword;
  logic want_gather;

  // ========================================================================
  // byte enable shaping
  function automatic logic [3:0] half_chunk(input logic [3:0] h);
    logic [3:0] r;
    r = 4'h0;
    if (h == 4'hf)
      r = 4'hf;
    else if (h[1:0] != 2'h0)
      r = (h[1:0] == 2'h3) ? 4'h3 : (h[0] ? 4'h1 : 4'h2);
    else if (h[3:2] != 2'h0)
      r = (h[3:2] == 2'h3) ? 4'hc : (h[2] ? 4'h4 : 4'h8);
    return r;
  endfunction

  // largest naturally aligned piece starting at the lowest set lane
  function automatic logic [7:0] simple_chunk(input logic [7:0] m);
    logic [7:0] r;
    r = 8'h00;
    if (m == ocp_biu_pkg::BE_FULL)
      r = m;
    else if (m[3:0] != 4'h0)
      r = {4'h0, half_chunk(m[3:0])};
    else
      r = {half_chunk(m[7:4]), 4'h0};
    return r;
  endfunction

  // ========================================================================
  // merge lookup
  assign is_word = (core_req.be == ocp_biu_pkg::BE_LO_WORD) ||
                   (core_req.be == ocp_biu_pkg::BE_HI_WORD);
  assign is_dword = core_req.be == ocp_biu_pkg::BE_FULL;
  assign want_gather = (core_req.policy == ocp_biu_pkg::POL_UCA) && (is_word || is_dword);

  for (genvar i = 0; i < ocp_biu_pkg::WB_ENTRIES; i++)
  begin : g_match
    assign merge_hit[i] = s.ent[i].valid && s.ent[i].mergeable && !s.ent[i].sealed &&
                          s.ent[i].tag == core_req.addr[31:5] &&
                          s.ent[i].gather == want_gather &&
                          (!want_gather || (is_word ? s.ent[i].gcount < 4'h8
                            : (!s.ent[i].gcount[0] && s.ent[i].gcount < 4'h7)));
  end

  // ========================================================================
  // next state
  always_comb
  begin
    logic [1:0] idx;
    logic found;
    logic push;
    logic pop;
    logic inc;
    logic dec;
    logic qpush;
    logic qpop;
    logic cmd_ok;
    logic dat_ok;
    logic [7:0] m;
    logic [7:0] be;
    next_s = s;
    core_req_ready = 1'b0;
    idx = 2'h0;
    found = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    inc = 1'b0;
    dec = 1'b0;
    qpush = 1'b0;
    qpop = core_rsp_ready && (s.qcnt != 2'h0);
    m = 8'h00;
    be = core_req.be;
    cmd_ok = 1'b0;
    dat_ok = 1'b0;
    for (int i = ocp_biu_pkg::WB_ENTRIES - 1; i >= 0; i--)
    begin
      if (merge_hit[i])
      begin
        idx = 2'(i);
        found = 1'b1;
      end
    end
    // read slot or write buffer, by operation and cache policy
    if (core_req.valid)
    begin
      case (core_req.op)
        ocp_biu_pkg::OP_LOAD, ocp_biu_pkg::OP_FETCH, ocp_biu_pkg::OP_BARRIER,
        ocp_biu_pkg::OP_STORE:
        begin
          if (core_req.op == ocp_biu_pkg::OP_STORE &&
              core_req.policy != ocp_biu_pkg::POL_WB)
          begin
            // write-through, uncached and accelerated stores reach memory
            if (want_gather && found)
            begin
              core_req_ready = 1'b1;
              for (int h = 0; h < 2; h++)
              begin
                if (is_dword || h == 0)
                begin
                  next_s.ent[idx].data[next_s.ent[idx].gcount[2:1]]
                    [next_s.ent[idx].gcount[0]*32 +: 32] =
                    (is_dword ? core_req.wdata[h*32 +: 32]
                     : (core_req.be[0] ? core_req.wdata[31:0] : core_req.wdata[63:32]));
                  next_s.ent[idx].mask[next_s.ent[idx].gcount[2:1]]
                    [next_s.ent[idx].gcount[0]*4 +: 4] = 4'hf;
                  next_s.ent[idx].gcount = next_s.ent[idx].gcount + 4'h1;
                end
              end
            end
            else if (!want_gather && found && core_req.policy == ocp_biu_pkg::POL_WT)
            begin
              core_req_ready = 1'b1;
              for (int b = 0; b < ocp_biu_pkg::BE_W; b++)
              begin
                if (core_req.be[b])
                  next_s.ent[idx].data[core_req.addr[4:3]][b*8 +: 8] = core_req.wdata[b*8 +: 8];
              end
              next_s.ent[idx].mask[core_req.addr[4:3]] =
                s.ent[idx].mask[core_req.addr[4:3]] | core_req.be;
            end
            else if (s.count < 3'(ocp_biu_pkg::WB_ENTRIES))
            begin
              core_req_ready = 1'b1;
              push = 1'b1;
              idx = s.head + s.count[1:0];
              next_s.ent[idx] = '0;
              next_s.ent[idx].valid = 1'b1;
              next_s.ent[idx].tag = core_req.addr[31:5];
              next_s.ent[idx].space = core_req.space;
              if (want_gather && core_req.addr[4:0] == 5'h00)
              begin
                next_s.ent[idx].mergeable = 1'b1;
                next_s.ent[idx].gather = 1'b1;
                next_s.ent[idx].data[0] = is_dword ? core_req.wdata
                  : {32'h0, core_req.be[0] ? core_req.wdata[31:0] : core_req.wdata[63:32]};
                next_s.ent[idx].mask[0] = is_dword ? ocp_biu_pkg::BE_FULL : ocp_biu_pkg::BE_LO_WORD;
                next_s.ent[idx].gcount = is_dword ? 4'h2 : 4'h1;
              end
              else
              begin
                next_s.ent[idx].mergeable = core_req.policy == ocp_biu_pkg::POL_WT;
                next_s.ent[idx].data[core_req.addr[4:3]] = core_req.wdata;
                next_s.ent[idx].mask[core_req.addr[4:3]] = core_req.be;
              end
            end
          end
          else if ((core_req.policy == ocp_biu_pkg::POL_WT ||
                    core_req.policy == ocp_biu_pkg::POL_WB) &&
                   core_req.hit && core_req.op != ocp_biu_pkg::OP_BARRIER)
            core_req_ready = 1'b1;
          else if (!s.rd_valid)
          begin
            core_req_ready = 1'b1;
            next_s.rd_valid = 1'b1;
            next_s.rd_barrier = core_req.op == ocp_biu_pkg::OP_BARRIER;
            // cached misses refill the whole line, missed doubleword first
            next_s.rd_burst = !next_s.rd_barrier &&
              (core_req.policy == ocp_biu_pkg::POL_WT || core_req.policy == ocp_biu_pkg::POL_WB);
            next_s.rd_addr = {core_req.addr[31:3], 3'h0};
            next_s.rd_space = core_req.space;
            if (next_s.rd_burst || next_s.rd_barrier)
              be = ocp_biu_pkg::BE_FULL;
            else if (aligned_byte_enable_mode && simple_chunk(core_req.be) != core_req.be)
              be = (core_req.be[3:0] != 4'h0) ? ocp_biu_pkg::BE_LO_WORD : ocp_biu_pkg::BE_HI_WORD;
            next_s.rd_be = be;
          end
        end
        ocp_biu_pkg::OP_EVICT:
        begin
          // dirty victim beats gather into one entry per line
          if (found && !want_gather)
          begin
            core_req_ready = 1'b1;
            next_s.ent[idx].data[core_req.addr[4:3]] = core_req.wdata;
            next_s.ent[idx].mask[core_req.addr[4:3]] = ocp_biu_pkg::BE_FULL;
          end
          else if (s.count < 3'(ocp_biu_pkg::WB_ENTRIES))
          begin
            core_req_ready = 1'b1;
            push = 1'b1;
            idx = s.head + s.count[1:0];
            next_s.ent[idx] = '0;
            next_s.ent[idx].valid = 1'b1;
            next_s.ent[idx].mergeable = 1'b1;
            next_s.ent[idx].tag = core_req.addr[31:5];
            next_s.ent[idx].space = core_req.space;
            next_s.ent[idx].data[core_req.addr[4:3]] = core_req.wdata;
            next_s.ent[idx].mask[core_req.addr[4:3]] = ocp_biu_pkg::BE_FULL;
          end
        end
        default:
          core_req_ready = 1'b0;
      endcase
    end
    // bus inputs, taken only on the input strobe
    cmd_ok = s.cmd_acc || (bus_in_strobe && s.req.mcmd != ocp_biu_pkg::CMD_IDLE &&
                           ocp_in.scmdaccept);
    dat_ok = s.dat_acc || (bus_in_strobe && s.wdat.mdatavalid && ocp_in.sdataaccept);
    next_s.cmd_acc = cmd_ok;
    next_s.dat_acc = dat_ok;
    if (bus_in_strobe && s.resp_acc && ocp_in.sresp == ocp_biu_pkg::RESP_DVA)
    begin
      qpush = 1'b1;
      next_s.q[s.qrd ^ (s.qcnt == 2'h1)] = '{data: ocp_in.sdata, first: s.rfirst,
        last: ocp_in.sresplast, fill: s.rfirst ? !ocp_in.sresplast : s.rburst};
      next_s.rfirst = ocp_in.sresplast;
      if (s.rfirst)
        next_s.rburst = !ocp_in.sresplast;
      if (ocp_in.sresplast)
      begin
        dec = 1'b1;
        next_s.barrier_wait = 1'b0;
      end
    end
    // bus outputs, changed only on the output strobe
    if (bus_out_strobe)
    begin
      next_s.cmd_acc = 1'b0;
      next_s.dat_acc = 1'b0;
      case (s.dr)
        ocp_biu_pkg::DR_IDLE:
        begin
          if (s.rd_valid && !s.barrier_wait && s.outstanding < 4'(MAX_READS) &&
              (!s.rd_barrier || (s.count == 3'h0 && s.outstanding == 4'h0)))
          begin
            next_s.rd_valid = 1'b0;
            next_s.req = '{mcmd: ocp_biu_pkg::CMD_RD, maddr: s.rd_addr, maddrspace: s.rd_space,
              mburstlength: s.rd_burst ? ocp_biu_pkg::LEN_BURST : ocp_biu_pkg::LEN_SINGLE,
              mburstseq: burst_xor_order ? ocp_biu_pkg::SEQ_XOR : ocp_biu_pkg::SEQ_WRAP,
              mbyteen: s.rd_be, mreqinfo: s.rd_barrier};
            next_s.dr = ocp_biu_pkg::DR_CMD;
          end
          else if (s.count != 3'h0 && !s.barrier_wait &&
                   (s.count > 3'h1 || !core_req.valid || &s.ent[s.head].mask))
          begin
            // oldest entry first keeps posted writes in program order
            next_s.ent[s.head].sealed = 1'b1;
            next_s.wburst = &s.ent[s.head].mask;
            next_s.beat = 2'h0;
            next_s.dsel = 2'h3;
            for (int d = ocp_biu_pkg::BURST_BEATS - 1; d >= 0; d--)
            begin
              if (s.ent[s.head].mask[d] != 8'h00)
                next_s.dsel = 2'(d);
            end
            m = s.ent[s.head].mask[next_s.dsel];
            next_s.req = '{mcmd: ocp_biu_pkg::CMD_WR,
              maddr: {s.ent[s.head].tag, next_s.wburst ? 2'h0 : next_s.dsel, 3'h0},
              maddrspace: s.ent[s.head].space,
              mburstlength: next_s.wburst ? ocp_biu_pkg::LEN_BURST : ocp_biu_pkg::LEN_SINGLE,
              mburstseq: ocp_biu_pkg::SEQ_WRAP,
              mbyteen: next_s.wburst ? ocp_biu_pkg::BE_FULL
                : (aligned_byte_enable_mode ? simple_chunk(m) : m),
              mreqinfo: 1'b0};
            next_s.dr = ocp_biu_pkg::DR_CMD;
          end
        end
        ocp_biu_pkg::DR_CMD:
        begin
          if (cmd_ok)
          begin
            next_s.req.mcmd = ocp_biu_pkg::CMD_IDLE;
            if (s.req.mcmd == ocp_biu_pkg::CMD_RD)
            begin
              inc = 1'b1;
              next_s.barrier_wait = s.req.mreqinfo;
              next_s.dr = ocp_biu_pkg::DR_IDLE;
            end
            else
            begin
              next_s.wdat = '{mdatavalid: 1'b1,
                mdata: s.ent[s.head].data[s.wburst ? 2'h0 : s.dsel],
                mdatabyteen: s.req.mbyteen, mdatalast: !s.wburst};
              next_s.dr = ocp_biu_pkg::DR_DATA;
            end
          end
        end
        ocp_biu_pkg::DR_DATA:
        begin
          if (dat_ok)
          begin
            if (s.wburst && s.beat != 2'h3)
            begin
              next_s.beat = s.beat + 2'h1;
              next_s.wdat.mdata = s.ent[s.head].data[next_s.beat];
              next_s.wdat.mdatalast = next_s.beat == 2'h3;
            end
            else
            begin
              next_s.wdat = '0;
              next_s.dr = ocp_biu_pkg::DR_IDLE;
              next_s.ent[s.head].mask[s.dsel] = s.ent[s.head].mask[s.dsel] & ~s.wdat.mdatabyteen;
              if (s.wburst || (next_s.ent[s.head].mask == '0))
              begin
                pop = 1'b1;
                next_s.ent[s.head].valid = 1'b0;
              end
            end
          end
        end
        default:
          next_s.dr = ocp_biu_pkg::DR_IDLE;
      endcase
    end
    next_s.head = s.head + {1'b0, pop};
    next_s.count = s.count + {2'h0, push} - {2'h0, pop};
    next_s.outstanding = s.outstanding + {3'h0, inc} - {3'h0, dec};
    next_s.qrd = s.qrd ^ qpop;
    next_s.qcnt = s.qcnt + {1'b0, qpush} - {1'b0, qpop};
    // with one input strobe per output strobe the two-entry buffer never overflows
    if (bus_out_strobe)
      next_s.resp_acc = next_s.qcnt != 2'h2;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.rfirst <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign core_rsp = s.q[s.qrd];
  assign core_rsp_valid = s.qcnt != 2'h0;
  assign ocp_req = s.req;
  assign ocp_wdata = s.wdat;
  assign ocp_resp_accept = s.resp_acc;
  assign wbuf_empty = s.count == 3'h0;
  assign reads_outstanding = s.outstanding;

  // ========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence seq_burst_wr_taken;
    ocp_req.mcmd == ocp_biu_pkg::CMD_WR && ocp_req.mburstlength == ocp_biu_pkg::LEN_BURST &&
    bus_in_strobe && ocp_in.scmdaccept;
  endsequence

  chk_read_limit: assert property (reads_outstanding <= 4'(MAX_READS))
    else $error("too many reads outstanding");
  chk_burst_shape: assert property (ocp_req.mcmd != ocp_biu_pkg::CMD_IDLE &&
    ocp_req.mburstlength != ocp_biu_pkg::LEN_SINGLE |-> ocp_req.mburstlength == ocp_biu_pkg::LEN_BURST)
    else $error("burst length not four");
  chk_burst_order: assert property (ocp_req.mcmd != ocp_biu_pkg::CMD_IDLE |->
    ocp_req.mburstseq == ocp_biu_pkg::SEQ_WRAP || ocp_req.mburstseq == ocp_biu_pkg::SEQ_XOR)
    else $error("illegal burst order");
  chk_simple_enables: assert property (aligned_byte_enable_mode && ocp_wdata.mdatavalid |->
    simple_chunk(ocp_wdata.mdatabyteen) == ocp_wdata.mdatabyteen)
    else $error("non-aligned write enables");
  chk_cmd_held: assert property (ocp_req.mcmd != ocp_biu_pkg::CMD_IDLE &&
    !(bus_in_strobe && ocp_in.scmdaccept) && !s.cmd_acc |=> $stable(ocp_req))
    else $error("request dropped before accept");
  chk_barrier_alone: assert property ($rose(ocp_req.mreqinfo) |->
    reads_outstanding == 4'h0 && wbuf_empty)
    else $error("barrier issued with traffic pending");
  chk_out_strobe: assert property (!$stable(ocp_req) |-> $past(bus_out_strobe))
    else $error("bus output changed off strobe");
  chk_burst_beats: assert property (seq_burst_wr_taken |-> ##[1:600]
    (ocp_wdata.mdatavalid && ocp_wdata.mdatalast && s.beat == 2'h3))
    else $error("write burst did not end on fourth beat");
  chk_single_thread: assert property (ocp_req.mcmd == ocp_biu_pkg::CMD_IDLE ||
    ocp_req.mcmd == ocp_biu_pkg::CMD_RD || ocp_req.mcmd == ocp_biu_pkg::CMD_WR)
    else $error("unexpected command");
endmodule
`default_nettype wire

// ==== testbench/ocp_bus_interface_write_buffer_tb.sv ====
// self-checking bench for the bus interface unit and its merging write buffer
`timescale 1ns/1ps
`default_nettype none
module ocp_bus_interface_write_buffer_tb;
  // ==========================================
  // signals and instances
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic strobe = 1'b1;
  logic aligned_byte_enable_mode = 1'b0;
  logic burst_xor_order = 1'b0;
  logic slow = 1'b0;
  ocp_biu_pkg::core_req_t core_req = '0;
  logic core_req_ready;
  logic core_rsp_valid;
  logic wbuf_empty;
  logic ocp_resp_accept;
  ocp_biu_pkg::core_rsp_t core_rsp;
  ocp_biu_pkg::ocp_req_t ocp_req;
  ocp_biu_pkg::ocp_wdata_t ocp_wdata;
  ocp_biu_pkg::ocp_in_t ocp_in;
  logic [3:0] reads_outstanding;
  logic rsp_ready = 1'b1;
  logic last_info;
  ocp_biu_pkg::core_rsp_t rsps[$];
  ocp_biu_pkg::ocp_req_t cmds[$];
  int wbeats = 0;
  int failures = 0;
  int n_tests = 0;
  always #12.5 core_clk = ~core_clk;
  ocp_bus_interface_write_buffer uut (.core_clk(core_clk), .resetn(resetn),
    .bus_in_strobe(strobe), .bus_out_strobe(strobe),
    .aligned_byte_enable_mode(aligned_byte_enable_mode), .burst_xor_order(burst_xor_order),
    .core_req(core_req), .core_req_ready(core_req_ready), .core_rsp(core_rsp),
    .core_rsp_valid(core_rsp_valid), .core_rsp_ready(rsp_ready), .ocp_req(ocp_req),
    .ocp_wdata(ocp_wdata), .ocp_resp_accept(ocp_resp_accept), .ocp_in(ocp_in),
    .wbuf_empty(wbuf_empty), .reads_outstanding(reads_outstanding));
  ocp_slave_model slave (.core_clk(core_clk), .slow(slow), .ocp_req(ocp_req),
    .ocp_wdata(ocp_wdata), .ocp_resp_accept(ocp_resp_accept), .ocp_in(ocp_in));
  always @(posedge core_clk)
  begin
    if (ocp_req.mcmd != ocp_biu_pkg::CMD_IDLE && ocp_in.scmdaccept)
      cmds.push_back(ocp_req);
    if (ocp_wdata.mdatavalid && ocp_in.sdataaccept)
      wbeats++;
    if (core_rsp_valid && rsp_ready)
      rsps.push_back(core_rsp);
  end
  // ==========================================
  // shared tasks
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input ocp_biu_pkg::op_t op, input ocp_biu_pkg::policy_t pol,
    input logic [31:0] a, input logic [7:0] be);
    int n;
    n = 0;
    core_req = '{1'b1, op, pol, 1'b0, a, be, {a, a}, 2'h1};
    do
    begin
      @(posedge core_clk);
      n++;
    end while (core_req_ready !== 1'b1 && n < 300);
    @(negedge core_clk);
    chk("request taken", 64'h1, 64'(n < 300));
  endtask
  task automatic expect_cmd(input string what, input logic [2:0] cmd, input logic [31:0] a,
    input logic [2:0] len, input logic [2:0] seq, input logic [7:0] be);
    ocp_biu_pkg::ocp_req_t r;
    core_req.valid = 1'b0;
    for (int i = 0; i < 400 && cmds.size() == 0; i++) @(negedge core_clk);
    r = (cmds.size() != 0) ? cmds.pop_front() : '0;
    last_info = r.mreqinfo;
    chk(what, {cmd, a, len, seq, be}, {r.mcmd, r.maddr, r.mburstlength, r.mburstseq, r.mbyteen});
    chk("address space", 64'h1, 64'(r.maddrspace));
  endtask
  task automatic settle;
    for (int i = 0; i < 400 && !(wbuf_empty === 1'b1 && reads_outstanding === 4'h0); i++)
      @(negedge core_clk);
    chk("idle after traffic", 64'h1, 64'(wbuf_empty === 1'b1 && reads_outstanding === 4'h0));
  endtask
  // ==========================================
  // scenarios
  task automatic t_read(input logic x);
    burst_xor_order = x;
    rsp_ready = !x;
    rsps.delete();
    send(ocp_biu_pkg::OP_LOAD, ocp_biu_pkg::POL_WT, 32'h1000_004c, 8'hf0);
    expect_cmd("miss read", ocp_biu_pkg::CMD_RD, 32'h1000_0048, ocp_biu_pkg::LEN_BURST,
      x ? ocp_biu_pkg::SEQ_XOR : ocp_biu_pkg::SEQ_WRAP, ocp_biu_pkg::BE_FULL);
    for (int i = 0; i < 400 && core_rsp_valid !== 1'b1; i++) @(negedge core_clk);
    chk("restart beat", {1'b1, 63'h1000_0048_0000_0000}, {core_rsp.first, core_rsp.data[62:0]});
    repeat (8) @(negedge core_clk);
    rsp_ready = 1'b1;
    settle();
    repeat (3) @(negedge core_clk);
    chk("read beats", 64'h4, 64'(rsps.size()));
    for (int i = 0; i < rsps.size() && i < 4; i++)
      chk("read beat", {i == 0, i == 3, 1'b1, 32'(i)},
        {rsps[i].first, rsps[i].last, rsps[i].fill, rsps[i].data[31:0]});
    burst_xor_order = 1'b0;
  endtask
  task automatic t_evict;
    int w;
    w = wbeats;
    slow = 1'b1;
    for (int i = 0; i < 4; i++)
      send(ocp_biu_pkg::OP_EVICT, ocp_biu_pkg::POL_WB, 32'h2000_0000 + 32'(i * 8), 8'hff);
    expect_cmd("evict burst", ocp_biu_pkg::CMD_WR, 32'h2000_0000, ocp_biu_pkg::LEN_BURST,
      ocp_biu_pkg::SEQ_WRAP, ocp_biu_pkg::BE_FULL);
    settle();
    chk("evict beats", 64'h4, 64'(wbeats - w));
    slow = 1'b0;
  endtask
  task automatic t_merge;
    send(ocp_biu_pkg::OP_STORE, ocp_biu_pkg::POL_WT, 32'h3000_0010, 8'h0f);
    send(ocp_biu_pkg::OP_STORE, ocp_biu_pkg::POL_WT, 32'h3000_0014, 8'hf0);
    send(ocp_biu_pkg::OP_STORE, ocp_biu_pkg::POL_UNCACHED, 32'h3000_0100, 8'h0f);
    expect_cmd("merged write", ocp_biu_pkg::CMD_WR, 32'h3000_0010, ocp_biu_pkg::LEN_SINGLE,
      ocp_biu_pkg::SEQ_WRAP, ocp_biu_pkg::BE_FULL);
    expect_cmd("second write", ocp_biu_pkg::CMD_WR, 32'h3000_0100, ocp_biu_pkg::LEN_SINGLE,
      ocp_biu_pkg::SEQ_WRAP, ocp_biu_pkg::BE_LO_WORD);
    settle();
  endtask
  task automatic t_aligned;
    aligned_byte_enable_mode = 1'b1;
    send(ocp_biu_pkg::OP_STORE, ocp_biu_pkg::POL_UNCACHED, 32'h5000_0000, 8'h0e);
    expect_cmd("byte piece", ocp_biu_pkg::CMD_WR, 32'h5000_0000, ocp_biu_pkg::LEN_SINGLE,
      ocp_biu_pkg::SEQ_WRAP, 8'h02);
    expect_cmd("half piece", ocp_biu_pkg::CMD_WR, 32'h5000_0000, ocp_biu_pkg::LEN_SINGLE,
      ocp_biu_pkg::SEQ_WRAP, 8'h0c);
    settle();
    send(ocp_biu_pkg::OP_LOAD, ocp_biu_pkg::POL_UNCACHED, 32'h5000_0008, 8'h0e);
    expect_cmd("widened read", ocp_biu_pkg::CMD_RD, 32'h5000_0008, ocp_biu_pkg::LEN_SINGLE,
      ocp_biu_pkg::SEQ_WRAP, ocp_biu_pkg::BE_LO_WORD);
    settle();
    aligned_byte_enable_mode = 1'b0;
  endtask
  task automatic t_gather;
    logic [31:0] a;
    for (int i = 0; i < 8; i++)
    begin
      a = (i == 0) ? 32'h6000_0000 : 32'h6000_0000 + 32'((8 - i) * 4);
      send(ocp_biu_pkg::OP_STORE, ocp_biu_pkg::POL_UCA, a, a[2] ? 8'hf0 : 8'h0f);
    end
    expect_cmd("gather burst", ocp_biu_pkg::CMD_WR, 32'h6000_0000, ocp_biu_pkg::LEN_BURST,
      ocp_biu_pkg::SEQ_WRAP, ocp_biu_pkg::BE_FULL);
    settle();
  endtask
  task automatic t_barrier;
    send(ocp_biu_pkg::OP_BARRIER, ocp_biu_pkg::POL_UNCACHED, 32'h7000_0004, 8'h0f);
    expect_cmd("barrier read", ocp_biu_pkg::CMD_RD, 32'h7000_0000, ocp_biu_pkg::LEN_SINGLE,
      ocp_biu_pkg::SEQ_WRAP, ocp_biu_pkg::BE_FULL);
    chk("barrier marker", 64'h1, 64'(last_info));
    settle();
  endtask
  // ==========================================
  // run control
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #(25 * 20000);
    failures++;
    complete_run();
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    chk("empty after reset", 64'h1, 64'(wbuf_empty === 1'b1));
    t_read(1'b0);
    t_read(1'b1);
    t_evict();
    t_merge();
    t_aligned();
    t_gather();
    t_barrier();
    complete_run();
  end
endmodule
`default_nettype wire

// ==== testbench/ocp_slave_model.sv ====
// behavioural bus slave that answers the master port of the bus interface unit
`timescale 1ns/1ps
`default_nettype none
module ocp_slave_model (
  input wire logic core_clk, // core clock
  input wire logic slow, // refuse commands on alternate cycles
  input wire ocp_biu_pkg::ocp_req_t ocp_req, // master request
  input wire ocp_biu_pkg::ocp_wdata_t ocp_wdata, // master write data
  input wire logic ocp_resp_accept, // master takes the response beat
  output ocp_biu_pkg::ocp_in_t ocp_in // slave answers
);
  // ==========================================
  // read queue and answers
  logic [34:0] rq[$];
  int beat = 0;
  logic tog = 1'b0;
  initial ocp_in = '0;
  // bookkeeping on pre-edge values, answers change at the falling edge
  always @(posedge core_clk)
  begin
    if (ocp_req.mcmd == ocp_biu_pkg::CMD_RD && ocp_in.scmdaccept)
      rq.push_back({ocp_req.mburstlength, ocp_req.maddr});
    if (ocp_in.sresp == ocp_biu_pkg::RESP_DVA && ocp_resp_accept)
    begin
      beat++;
      if (ocp_in.sresplast)
      begin
        void'(rq.pop_front());
        beat = 0;
      end
    end
  end
  always @(negedge core_clk)
  begin
    tog = ~tog;
    ocp_in.scmdaccept = (ocp_req.mcmd != ocp_biu_pkg::CMD_IDLE) && !(slow && tog);
    ocp_in.sdataaccept = ocp_wdata.mdatavalid;
    if (rq.size() != 0)
    begin
      ocp_in.sresp = ocp_biu_pkg::RESP_DVA;
      ocp_in.sdata = {rq[0][31:0], 32'(beat)};
      ocp_in.sresplast = (beat == int'(rq[0][34:32]) - 1);
    end
    else
    begin
      // released data lines do not keep the last value
      ocp_in.sresp = 2'h0;
      ocp_in.sdata = ~ocp_in.sdata;
      ocp_in.sresplast = 1'b0;
    end
  end
endmodule
`default_nettype wire
